// ### src/spi_wm_consts.vh
// register offsets, field positions, reset values and word length boundaries
`ifndef SPI_WM_CONSTS_VH
`define SPI_WM_CONSTS_VH
// register indices on the plain register port
`define ADDR_MASK_HIGH 3'h0
`define ADDR_FILL_LOW 3'h1
`define ADDR_FILL_HIGH 3'h2
`define ADDR_BAUD 3'h3
`define ADDR_CONTROL 3'h4
`define ADDR_STATUS 3'h5
// watermark_interrupt_mask_high fields
`define RX_EN_BIT 15
`define RX_LVL_HI 13
`define RX_LVL_LO 8
`define TX_EN_BIT 7
`define TX_LVL_HI 5
`define TX_LVL_LO 0
// control register fields
`define CTL_ENABLE_BIT 0
`define CTL_FILL_EN_BIT 1
`define CTL_EVENTS_HI 9
`define CTL_EVENTS_LO 2
// reset values
`define MASK_HIGH_RESET 16'h0000
`define FILL_RESET 16'h0000
`define BAUD_RESET 13'h0000
`define CTL_RESET 10'h000
// word length boundaries, in bits minus one
`define WLEN_8 5'h07
`define WLEN_16 5'h0F
`define WLEN_24 5'h17
`endif

// ### src/spi_wm_skid.v
// two-entry buffer with valid and ready on both sides
module spi_wm_skid #(
   parameter WIDTH = 32
) (
   input wire clk_sys,
   input wire sys_rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:1];
   reg wr_ptr_r;
   reg rd_ptr_r;
   reg [1:0] count_r;
   wire push;
   wire pop;

   assign in_ready = (count_r != 2'h2);
   assign out_valid = (count_r != 2'h0);
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // pointers and occupancy
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push)
            wr_ptr_r <= ~wr_ptr_r;
         if (pop)
            rd_ptr_r <= ~rd_ptr_r;
         if (push & ~pop)
            count_r <= count_r + 2'h1;
         else if (pop & ~push)
            count_r <= count_r - 2'h1;
      end
   end

   // storage, no reset needed
   always @(posedge clk_sys) begin
      if (push)
         mem_r[wr_ptr_r] <= in_data;
   end
endmodule

// ### src/spi_watermark_underrun_logic.v
// watermark interrupts, underrun fill word and baud clock of a serial unit
//
// Notes on behaviour
// [R1] rx watermark when level <= entry count
// [R2] tx watermark only when level equals count
// [R3] level above buffer depth never matches
// [R4] level bits 2,3,4 exist by depth
// [R5] rx level bits 13:8, enable bit 15
// [R6] tx level bits 5:0, enable bit 7
// [R7] bits 14 and 6 read zero
// [R8] underrun sends fill word when enabled
// [R9] 9-16 bit uses low 16, 2-8 low 8
// [R10] 25-32 full upper half, 17-24 bits 23:16
// [R11] serial clock is bus clock / 2(div+1)
// [R12] entry counts are occupied buffer entries
// [R13] software keeps divisor still while enabled
// [R14] watermarks join other events into one request
`include "spi_wm_consts.vh"
module spi_watermark_underrun_logic #(
   parameter BUFFER_DEPTH = 8,
   parameter WORD_WIDTH = 32
) (
   input wire clk_sys,
   input wire sys_rst,
   // register port
   input wire [2:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [15:0] reg_rdata,
   // unit side
   input wire [5:0] rx_entry_count,
   input wire [5:0] tx_entry_count,
   input wire [4:0] variable_word_length,
   input wire tx_underrun,
   input wire [7:0] other_events,
   // transmit words from the buffer
   input wire tx_word_valid,
   output wire tx_word_ready,
   input wire [WORD_WIDTH-1:0] tx_word_data,
   // words toward the shifter
   output wire shift_valid,
   input wire shift_ready,
   output wire [WORD_WIDTH-1:0] shift_data,
   output wire shift_is_fill,
   // serial clock and request
   output reg serial_clock,
   output reg serial_clock_tick,
   output reg module_enable,
   output reg irq_request,
   output reg rx_watermark_hit,
   output reg tx_watermark_hit
);
   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   reg rx_watermark_irq_enable_r;
   reg tx_watermark_irq_enable_r;
   reg [5:0] rx_watermark_level_r;
   reg [5:0] tx_watermark_level_r;
   reg [15:0] fill_low_r;
   reg [15:0] fill_high_r;
   reg [12:0] baud_divisor_r;
   reg [9:0] control_r;
   reg [12:0] baud_count_r;
   reg [12:0] baud_count_nxt;
   reg rx_hit_nxt;
   reg tx_hit_nxt;
   wire underrun_fill_enable;
   wire [5:0] impl_mask;
   wire [7:0] event_enables;
   wire [WORD_WIDTH-1:0] underrun_fill_word;
   wire [WORD_WIDTH-1:0] pick_data;
   wire pick_valid;
   wire pick_ready;
   wire [WORD_WIDTH:0] buf_out;
   reg [15:0] read_mux;

   assign underrun_fill_enable = control_r[`CTL_FILL_EN_BIT];
   assign event_enables = control_r[`CTL_EVENTS_HI:`CTL_EVENTS_LO];

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------
   // implemented level bits for a given buffer depth
   function [5:0] level_bits;
      input integer depth;
      begin
         level_bits = 6'h23; // bits 5,1,0 always present
         if (depth >= 8)
            level_bits = level_bits | 6'h04; // [R4]
         if (depth >= 16)
            level_bits = level_bits | 6'h08; // [R4]
         if (depth >= 32)
            level_bits = level_bits | 6'h10; // [R4]
      end
   endfunction

   // a level is valid only up to the buffer depth
   function level_ok;
      input [5:0] level;
      begin
         level_ok = ({26'h0, level} <= BUFFER_DEPTH); // [R3]
      end
   endfunction

   assign impl_mask = level_bits(BUFFER_DEPTH);

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rx_watermark_irq_enable_r <= 1'b0;
         tx_watermark_irq_enable_r <= 1'b0;
         rx_watermark_level_r <= 6'h00;
         tx_watermark_level_r <= 6'h00;
         fill_low_r <= `FILL_RESET;
         fill_high_r <= `FILL_RESET;
         baud_divisor_r <= `BAUD_RESET;
         control_r <= `CTL_RESET;
      end else if (reg_write) begin
         case (reg_addr)
            `ADDR_MASK_HIGH: begin
               rx_watermark_irq_enable_r <= reg_wdata[`RX_EN_BIT]; // [R5]
               rx_watermark_level_r <=
                  reg_wdata[`RX_LVL_HI:`RX_LVL_LO] & impl_mask; // [R5]
               tx_watermark_irq_enable_r <= reg_wdata[`TX_EN_BIT]; // [R6]
               tx_watermark_level_r <=
                  reg_wdata[`TX_LVL_HI:`TX_LVL_LO] & impl_mask; // [R6]
            end
            `ADDR_FILL_LOW: fill_low_r <= reg_wdata;
            `ADDR_FILL_HIGH: fill_high_r <= reg_wdata;
            `ADDR_BAUD: baud_divisor_r <= reg_wdata[12:0]; // [R13]
            `ADDR_CONTROL: control_r <= reg_wdata[9:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------
   always @* begin
      case (reg_addr)
         `ADDR_MASK_HIGH:
            read_mux = {rx_watermark_irq_enable_r, 1'b0, // [R7]
               rx_watermark_level_r, tx_watermark_irq_enable_r,
               1'b0, tx_watermark_level_r};
         `ADDR_FILL_LOW: read_mux = fill_low_r;
         `ADDR_FILL_HIGH: read_mux = fill_high_r;
         `ADDR_BAUD: read_mux = {3'h0, baud_divisor_r};
         `ADDR_CONTROL: read_mux = {6'h00, control_r};
         `ADDR_STATUS:
            read_mux = {2'h0, rx_entry_count, irq_request,
               tx_watermark_hit, tx_entry_count};
         default: read_mux = 16'h0000;
      endcase
   end

   // read data valid in the cycle after the strobe only
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         reg_rdata <= 16'h0000;
      else if (reg_read)
         reg_rdata <= read_mux;
      else
         reg_rdata <= 16'h0000;
   end

   // ------------------------------------------------------------
   // watermark comparison and request
   // ------------------------------------------------------------
   always @* begin
      // counts are buffer occupancy from the unit [R12]
      rx_hit_nxt = rx_watermark_irq_enable_r &
         level_ok(rx_watermark_level_r) &
         (rx_watermark_level_r <= rx_entry_count); // [R1] [R3]
      tx_hit_nxt = tx_watermark_irq_enable_r &
         level_ok(tx_watermark_level_r) &
         (tx_watermark_level_r == tx_entry_count); // [R2] [R3]
   end

   // evaluated every cycle; module enable acts as reset
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rx_watermark_hit <= 1'b0;
         tx_watermark_hit <= 1'b0;
         irq_request <= 1'b0;
         module_enable <= 1'b0;
      end else begin
         module_enable <= control_r[`CTL_ENABLE_BIT];
         rx_watermark_hit <= rx_hit_nxt & module_enable;
         tx_watermark_hit <= tx_hit_nxt & module_enable;
         irq_request <= module_enable & (rx_hit_nxt | tx_hit_nxt |
            (|(other_events & event_enables))); // [R14]
      end
   end

   // ------------------------------------------------------------
   // underrun fill word
   // ------------------------------------------------------------
   // fill word trimmed to the selected word length
   assign underrun_fill_word =
      (variable_word_length <= `WLEN_8) ?
         {{(WORD_WIDTH-8){1'b0}}, fill_low_r[7:0]} : // [R9]
      (variable_word_length <= `WLEN_16) ?
         {{(WORD_WIDTH-16){1'b0}}, fill_low_r} : // [R9]
      (variable_word_length <= `WLEN_24) ?
         {{(WORD_WIDTH-24){1'b0}}, fill_high_r[7:0], fill_low_r} : // [R10]
         {fill_high_r, fill_low_r}; // [R10]

   // substitute fill word only when underrun and enabled
   assign pick_valid = module_enable &
      (tx_word_valid | (tx_underrun & underrun_fill_enable)); // [R8]
   assign pick_data = tx_word_valid ? tx_word_data :
      underrun_fill_word; // [R8]
   assign tx_word_ready = pick_ready & module_enable;

   spi_wm_skid #(
      .WIDTH(WORD_WIDTH + 1)
   ) u_buf (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .in_valid(pick_valid),
      .in_ready(pick_ready),
      .in_data({~tx_word_valid, pick_data}),
      .out_valid(shift_valid),
      .out_ready(shift_ready),
      .out_data(buf_out)
   );

   assign shift_is_fill = buf_out[WORD_WIDTH];
   assign shift_data = buf_out[WORD_WIDTH-1:0];

   // ------------------------------------------------------------
   // baud clock
   // ------------------------------------------------------------
   // toggle every divisor+1 cycles gives bus clock / 2(div+1)
   always @* begin
      if (baud_count_r >= baud_divisor_r)
         baud_count_nxt = 13'h0000;
      else
         baud_count_nxt = baud_count_r + 13'h0001;
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         baud_count_r <= 13'h0000;
         serial_clock <= 1'b0;
         serial_clock_tick <= 1'b0;
      end else if (!module_enable) begin
         baud_count_r <= 13'h0000;
         serial_clock <= 1'b0;
         serial_clock_tick <= 1'b0;
      end else begin
         baud_count_r <= baud_count_nxt;
         serial_clock_tick <= (baud_count_r >= baud_divisor_r); // [R11]
         if (baud_count_r >= baud_divisor_r)
            serial_clock <= ~serial_clock; // [R11]
      end
   end
endmodule

// ### test/spi_wm_properties.sv
// concurrent checks on watermark, buffer and baud behaviour
module spi_wm_props #(
   parameter BUFFER_DEPTH = 8,
   parameter WORD_WIDTH = 32
) (
   input logic clk_sys,
   input logic sys_rst,
   input logic [2:0] reg_addr,
   input logic [15:0] reg_wdata,
   input logic reg_write,
   input logic reg_read,
   input logic [15:0] reg_rdata,
   input logic [5:0] rx_entry_count,
   input logic [5:0] tx_entry_count,
   input logic shift_valid,
   input logic shift_ready,
   input logic [WORD_WIDTH-1:0] shift_data,
   input logic serial_clock_tick,
   input logic module_enable,
   input logic irq_request,
   input logic rx_watermark_hit,
   input logic tx_watermark_hit
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // shadow of mask and divisor registers
   // ----------------------------------------
   logic [5:0] rx_lvl_r, tx_lvl_r, keep;
   logic rx_en_r, tx_en_r, seen_r, wr_d_r, calm;
   logic [12:0] div_r, gap_r;
   assign keep = 6'h23 | (BUFFER_DEPTH >= 8 ? 6'h04 : 6'h00)
      | (BUFFER_DEPTH >= 16 ? 6'h08 : 6'h00)
      | (BUFFER_DEPTH >= 32 ? 6'h10 : 6'h00);
   // no register write near the sampled edge
   assign calm = module_enable && !reg_write && !wr_d_r;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // mirror writes and measure tick spacing
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         {rx_en_r, rx_lvl_r, tx_en_r, tx_lvl_r} <= 14'h0000;
         {div_r, gap_r, seen_r, wr_d_r} <= 28'h0000000;
      end else begin
         if (reg_write && reg_addr == 3'h0) begin
            rx_en_r <= reg_wdata[15];
            rx_lvl_r <= reg_wdata[13:8] & keep;
            tx_en_r <= reg_wdata[7];
            tx_lvl_r <= reg_wdata[5:0] & keep;
         end
         if (reg_write && reg_addr == 3'h3) div_r <= reg_wdata[12:0];
         gap_r <= serial_clock_tick ? 13'h0000 : gap_r + 13'h0001;
         seen_r <= module_enable && (seen_r || serial_clock_tick);
         wr_d_r <= reg_write;
      end
   end
   mask_fields_a: assert property (
      $past(reg_read) && $past(reg_addr) == 3'h0
      |-> reg_rdata == {rx_en_r, 1'b0, rx_lvl_r, tx_en_r, 1'b0, tx_lvl_r})
      else $error("mask register read back wrong");
   tx_hit_fire_a: assert property (
      calm && tx_en_r && tx_lvl_r <= BUFFER_DEPTH
      && tx_entry_count == tx_lvl_r |=> tx_watermark_hit)
      else $error("tx watermark missed");
   tx_hit_cause_a: assert property (tx_watermark_hit |-> $past(tx_en_r)
      && $past(tx_entry_count) == $past(tx_lvl_r)
      && $past(tx_lvl_r) <= BUFFER_DEPTH) else $error("tx watermark spurious");
   rx_hit_fire_a: assert property (
      calm && rx_en_r && rx_lvl_r <= BUFFER_DEPTH
      && rx_entry_count >= rx_lvl_r |=> rx_watermark_hit)
      else $error("rx watermark missed");
   rx_hit_cause_a: assert property (rx_watermark_hit |-> $past(rx_en_r)
      && $past(rx_entry_count) >= $past(rx_lvl_r)
      && $past(rx_lvl_r) <= BUFFER_DEPTH) else $error("rx watermark spurious");
   irq_gate_a: assert property (!module_enable && !$past(module_enable)
      |-> !irq_request) else $error("request while disabled");
   skid_hold_a: assert property (shift_valid && !shift_ready |=> shift_valid
      && $stable(shift_data)) else $error("stalled word changed");
   baud_gap_a: assert property (serial_clock_tick && seen_r
      |-> gap_r == div_r) else $error("serial clock spacing wrong");
endmodule

bind spi_watermark_underrun_logic spi_wm_props #(
   .BUFFER_DEPTH(BUFFER_DEPTH), .WORD_WIDTH(WORD_WIDTH)) props (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .rx_entry_count(rx_entry_count),
   .tx_entry_count(tx_entry_count), .shift_valid(shift_valid),
   .shift_ready(shift_ready), .shift_data(shift_data),
   .serial_clock_tick(serial_clock_tick), .module_enable(module_enable),
   .irq_request(irq_request), .rx_watermark_hit(rx_watermark_hit),
   .tx_watermark_hit(tx_watermark_hit));

// ### test/shift_sink.sv
// far-side shifter model that takes words with random stalls
module shift_sink (
   input logic clk_sys,
   input logic sys_rst,
   input logic stall,
   output logic shift_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // ready dithers at random and stays low while stalled
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) shift_ready <= 1'b0;
      else shift_ready <= !stall && ($urandom_range(0, 3) != 0);
   end
endmodule

// ### test/spi_watermark_underrun_logic_tb.sv
// self-checking bench for the watermark and underrun fill block
module spi_watermark_underrun_logic_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
   logic tx_underrun = 1'b0, tx_word_valid = 1'b0, stall = 1'b0, rd_pend = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000, flo, fhi;
   logic [5:0] rx_entry_count = 6'h00, tx_entry_count = 6'h00, lv, t;
   logic [4:0] variable_word_length = 5'h1F;
   logic [7:0] other_events = 8'h00;
   logic [31:0] tx_word_data = 32'h00000000, f;
   logic [32:0] m, e, exp_q[$], msk_q[$];
   logic [15:0] rd_q[$];
   logic [5:0] lv_t[8] = '{6'h00, 6'h01, 6'h02, 6'h05,
      6'h07, 6'h08, 6'h20, 6'h23};
   logic [4:0] wl_t[8] = '{5'h1F, 5'h18, 5'h17, 5'h10, 5'h0F, 5'h08, 5'h07, 5'h01};
   wire [15:0] reg_rdata;
   wire [31:0] shift_data;
   wire tx_word_ready, shift_valid, shift_ready, shift_is_fill, irq_request;
   wire rx_hit, tx_hit;
   int error_cnt = 0, checked = 0, cyc = 0, n;
   spi_watermark_underrun_logic #(.BUFFER_DEPTH(8), .WORD_WIDTH(32)) dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .rx_entry_count(rx_entry_count),
      .tx_entry_count(tx_entry_count), .variable_word_length(variable_word_length),
      .tx_underrun(tx_underrun), .other_events(other_events),
      .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready),
      .tx_word_data(tx_word_data), .shift_valid(shift_valid),
      .shift_ready(shift_ready), .shift_data(shift_data),
      .shift_is_fill(shift_is_fill), .serial_clock(), .serial_clock_tick(),
      .module_enable(), .irq_request(irq_request),
      .rx_watermark_hit(rx_hit), .tx_watermark_hit(tx_hit));
   shift_sink sink (.clk_sys(clk_sys), .sys_rst(sys_rst), .stall(stall),
      .shift_ready(shift_ready));
   // ----------------------------------------
   // clock, watchdog and shared tasks
   // ----------------------------------------
   always #20 clk_sys = ~clk_sys;
   task automatic stop_test;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string what, input logic [32:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // one register cycle; reads note the expected data
   task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
      reg_write <= w;
      reg_read <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) rd_q.push_back(d);
      @(posedge clk_sys);
   endtask
   task automatic idle(input int k);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      repeat (k) @(posedge clk_sys);
   endtask
   task automatic drain;
      while (shift_valid) @(posedge clk_sys);
   endtask
   // watchdog and scoreboard of read data and shifted words
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test;
      end
      if (rd_pend) check("read data", reg_rdata, rd_q.pop_front());
      rd_pend <= reg_read;
      if (shift_valid && shift_ready) begin
         m = msk_q.size() ? msk_q.pop_front() : 33'h1FFFFFFFF;
         e = exp_q.size() ? exp_q.pop_front() : 33'h0;
         // fill words only carry the bits of the selected length
         check("shift word", {shift_is_fill, shift_data} & m, e & m);
      end
   end
   initial begin
      void'($urandom(29));
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (n = 0; n < 8; n++) bus(0, n[2:0], 16'h0000);
      bus(1, 3'h0, 16'hFFFF);
      bus(0, 3'h0, 16'hA7A7);
      bus(1, 3'h6, 16'hFFFF);
      bus(0, 3'h6, 16'h0000);
      bus(1, 3'h3, 16'h0003);
      bus(1, 3'h4, 16'h0001);
      foreach (lv_t[i]) begin
         lv = lv_t[i] & 6'h27;
         bus(1, 3'h0, {2'b10, lv_t[i], 2'b10, lv_t[i]});
         repeat (3) begin
            n = $urandom_range(0, 8);
            t = (n[0] && lv <= 6'h08) ? lv : n[5:0];
            rx_entry_count <= n[5:0];
            tx_entry_count <= t;
            idle(3);
            check("rx hit", rx_hit, lv <= 6'h08 && lv <= n[5:0]);
            check("tx hit", tx_hit, lv <= 6'h08 && lv == t);
            check("irq", irq_request, lv <= 6'h08 && (lv <= n[5:0] || lv == t));
         end
      end
      bus(1, 3'h0, 16'h0000);
      bus(1, 3'h4, 16'h0005);
      other_events <= 8'h01;
      idle(3);
      check("event irq", irq_request, 1'b1);
      other_events <= 8'h02;
      idle(3);
      check("masked irq", irq_request, 1'b0);
      flo = $urandom;
      fhi = $urandom;
      stall <= 1'b1;
      bus(1, 3'h1, flo);
      bus(1, 3'h2, fhi);
      bus(0, 3'h2, fhi);
      bus(1, 3'h4, 16'h0003);
      idle(1);
      for (n = 0; n < 6; n++) begin
         f = $urandom;
         tx_word_valid <= 1'b1;
         tx_word_data <= f;
         exp_q.push_back({1'b0, f});
         if (n == 2) begin
            idle(2);
            check("full refuses", tx_word_ready, 1'b0);
            stall <= 1'b0;
         end
         do @(posedge clk_sys); while (!tx_word_ready);
      end
      tx_word_valid <= 1'b0;
      idle(1);
      drain;
      foreach (wl_t[i]) begin
         variable_word_length <= wl_t[i];
         idle(1);
         tx_underrun <= 1'b1;
         exp_q.push_back({1'b1, fhi, flo});
         msk_q.push_back({1'b1, wl_t[i] > 5'h17 ? 32'hFFFFFFFF :
            wl_t[i] > 5'h0F ? 32'h00FFFFFF :
            wl_t[i] > 5'h07 ? 32'h0000FFFF : 32'h000000FF});
         idle(1);
         tx_underrun <= 1'b0;
         idle(2);
         drain;
      end
      bus(1, 3'h4, 16'h0001);
      idle(1);
      tx_underrun <= 1'b1;
      idle(1);
      tx_underrun <= 1'b0;
      idle(8);
      check("words left", exp_q.size(), 0);
      stop_test;
   end
endmodule
